// [dv/isb_master.sv]
`timescale 1ns/100ps
`default_nettype none
// behavioural two-wire bus controller; the line has a pull-up, so release reads as one
module isb_master #(
  parameter int Q = 10
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // bus idles released, clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one third of a bus clock bit, pins moved just after a clock edge
  task automatic step(input logic c, input logic d);
    @(posedge clock);
    scl <= c;
    sda_rel <= d;
    repeat (Q - 1) @(posedge clock);
  endtask
  // start, or repeated start from the middle of a frame
  task automatic start(input logic rep);
    if (rep) step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // stop ends the frame with both lines high
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // data changes only while clock is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_line;
    step(1'b0, b);
  endtask
  // eight bits msb first, ninth slot released for the target's answer
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(1'b1, b);
    ack = ~b;
  endtask
endmodule
`default_nettype wire

// [dv/isb_target_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module isb_target_bench;
  import isb_pkg::*;
  logic clock, reset, sda_out, sda_oe_n, wr_valid, wr_ready, busy, scl, sda_rel;
  logic [ISB_CODE_W-1:0] control_code;
  logic [ISB_ADDR_W-1:0] wr_addr, rd_addr;
  logic [ISB_DATA_W-1:0] wr_data, rd_data;
  logic [ISB_DATA_W-1:0] mem [0:2**ISB_ADDR_W-1]; // memory behind the write stream
  int n_errors, samples_checked, n_writes;
  // open-drain line: low if either party pulls it
  wire sda_line = sda_rel & (sda_oe_n | sda_out);

  isb_target isb_target_i (.clock, .reset, .scl_in(scl), .sda_in(sda_line), .sda_out,
    .sda_oe_n, .control_code, .wr_valid, .wr_ready, .wr_addr, .wr_data, .rd_addr,
    .rd_data, .busy);
  isb_master #(.Q(10)) isb_master_i (.clock, .sda_line, .scl, .sda_rel);

  // combinational read port, writes land on accepted beats
  assign rd_data = mem[rd_addr];
  always @(posedge clock) begin
    if (wr_valid && wr_ready) begin
      mem[wr_addr] <= wr_data;
      n_writes++;
    end
  end

  // free-running core clock, 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // control byte for a write, then the word address; frame left open
  task automatic set_ptr(input logic [2:0] blk, input logic [7:0] word);
    logic [7:0] r;
    logic a;
    isb_master_i.start(1'b0);
    isb_master_i.byte_io({control_code, blk, 1'b0}, r, a);
    check(a, 1'b1);
    isb_master_i.byte_io(word, r, a);
    check(a, 1'b1);
  endtask

  // single byte write; commit is checked before the stop goes out
  task automatic write_byte(input logic [2:0] blk, input logic [7:0] word, d,
    input logic exp_ack);
    logic [7:0] r;
    logic a;
    set_ptr(blk, word);
    isb_master_i.byte_io(d, r, a);
    check(a, exp_ack);
    if (exp_ack && wr_ready) check(mem[{blk, word}], d);
    isb_master_i.stop();
    check(busy, 1'b0);
  endtask

  // pointer set by an aborted write, then read after a repeated start
  task automatic rand_read(input logic [2:0] blk, input logic [7:0] word, exp);
    logic [7:0] r;
    logic a;
    int n0;
    n0 = n_writes;
    set_ptr(blk, word);
    isb_master_i.start(1'b1);
    check(rd_addr, {blk, word});
    isb_master_i.byte_io({control_code, blk, 1'b1}, r, a);
    check(a, 1'b1);
    isb_master_i.byte_io(8'hFF, r, a);
    check(r, exp);
    isb_master_i.stop();
    check(n_writes, n0);
  endtask

  // read with no address phase returns the byte at the pointer
  task automatic cur_read(input logic [7:0] exp);
    logic [7:0] r;
    logic a;
    isb_master_i.start(1'b0);
    isb_master_i.byte_io({control_code, 3'h0, 1'b1}, r, a);
    check(a, 1'b1);
    isb_master_i.byte_io(8'hFF, r, a);
    check(r, exp);
    isb_master_i.stop();
  endtask

  // wrong code: no answer to any byte of the frame, nothing stored
  task automatic mismatch;
    logic [7:0] r;
    logic a;
    int n0;
    n0 = n_writes;
    isb_master_i.start(1'b0);
    isb_master_i.byte_io({~control_code, 3'h1, 1'b0}, r, a);
    check(a, 1'b0);
    isb_master_i.byte_io(8'h10, r, a);
    check(a, 1'b0);
    isb_master_i.byte_io(8'h99, r, a);
    check(a, 1'b0);
    isb_master_i.stop();
    check(n_writes, n0);
  endtask

  // memory stalls: fifo plus output stage hold nine bytes, the tenth is refused
  task automatic fifo_full;
    int n0;
    int n_q;
    n0 = n_writes;
    n_q = ISB_FIFO_DEPTH + 1;
    @(posedge clock);
    wr_ready <= 1'b0;
    for (int i = 0; i < n_q; i++) write_byte(3'h1, i[7:0], 8'h40 + i[7:0], 1'b1);
    write_byte(3'h1, 8'h20, 8'hEE, 1'b0);
    @(posedge clock);
    wr_ready <= 1'b1;
    for (int i = 0; i < 200 && n_writes != n0 + n_q; i++) @(posedge clock);
    check(n_writes, n0 + n_q);
    for (int i = 0; i < n_q; i++) check(mem[{3'h1, i[7:0]}], 8'h40 + i[7:0]);
    check(mem[{3'h1, 8'h20}], 8'h20 ^ 8'hC3);
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    wr_ready = 1'b1;
    control_code = 4'h5;
    for (int i = 0; i < 2**ISB_ADDR_W; i++) mem[i] = i[7:0] ^ 8'hC3;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    write_byte(3'h5, 8'h3C, 8'hA5, 1'b1);
    rand_read(3'h2, 8'h81, 8'h81 ^ 8'hC3);
    cur_read(8'h81 ^ 8'hC3);
    rand_read(3'h5, 8'h3C, 8'hA5);
    mismatch();
    @(posedge clock);
    control_code <= 4'hA;
    write_byte(3'h7, 8'hFF, 8'h01, 1'b1);
    cur_read(8'h01);
    fifo_full();
    stop_test();
  end
endmodule
`default_nettype wire

// [hw/isb_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
// small synchronous fifo with valid/ready on both sides
module isb_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [PW:0] wr_ptr;            // extra bit tells full from empty
  logic [PW:0] rd_ptr;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[PW-1:0]];

  // pointers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // data array, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [hw/isb_pkg.sv]
package isb_pkg;
  // two-wire byte-access target constants
  localparam int ISB_CODE_W = 4;          // control code width
  localparam int ISB_BLK_W = 3;           // block address width
  localparam int ISB_WORD_W = 8;          // word address width
  localparam int ISB_ADDR_W = ISB_BLK_W + ISB_WORD_W;
  localparam int ISB_DATA_W = 8;          // byte width
  localparam int ISB_FIFO_DEPTH = 8;      // write fifo depth
  localparam int ISB_BIT_CNT_W = 4;       // bit counter width
  localparam logic [3:0] ISB_LAST_BIT = 4'h7;  // index of eighth bit
  localparam logic [3:0] ISB_ACK_BIT = 4'h8;   // ninth clock slot
  localparam logic [3:0] ISB_CODE_DEF = 4'h1;  // default control code, arbitrary
  localparam int ISB_SYNC_STAGES = 3;     // pin synchroniser depth
  // bus decoder phases
  typedef enum logic [2:0] {
    ISB_IDLE,
    ISB_CTRL,
    ISB_WORD,
    ISB_DATA_IN,
    ISB_DATA_OUT,
    ISB_IGNORE
  } isb_state_e;
endpackage

// [hw/isb_target.sv]
`timescale 1ns/100ps
`default_nettype none
module isb_target (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_in,                                 // serial clock pin
  input wire logic sda_in,                                 // serial data pin
  output logic sda_out,                                    // always low when driving
  output logic sda_oe_n,                                   // low while pulling sda
  input wire logic [isb_pkg::ISB_CODE_W-1:0] control_code, // programmed match value
  output logic wr_valid,                                   // write toward memory
  input wire logic wr_ready,
  output logic [isb_pkg::ISB_ADDR_W-1:0] wr_addr,
  output logic [isb_pkg::ISB_DATA_W-1:0] wr_data,
  output logic [isb_pkg::ISB_ADDR_W-1:0] rd_addr,          // memory read address
  input wire logic [isb_pkg::ISB_DATA_W-1:0] rd_data,      // combinational read data
  output logic busy                                        // inside a transaction
);
  import isb_pkg::*;

  localparam int FW = ISB_ADDR_W + ISB_DATA_W;

  // three-stage synchronisers; stage 1 read only by stage 2
  logic [ISB_SYNC_STAGES-1:0] scl_sync;
  logic [ISB_SYNC_STAGES-1:0] sda_sync;
  logic scl_q;  // filtered level
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  isb_state_e state;
  logic [ISB_BIT_CNT_W-1:0] bit_cnt;         // 0..7 data, 8 ack slot
  logic [ISB_DATA_W-1:0] shreg;              // receive shifter
  logic [ISB_DATA_W-1:0] tx_byte;            // transmit shifter
  logic [ISB_BLK_W-1:0] block_address_bits;  // upper pointer bits
  logic [ISB_ADDR_W-1:0] pointer;            // internal address pointer
  logic ack_drive;                           // pulling sda for ack
  logic rd_bit;                              // read data bit on line
  logic rd_active;                           // read data phase driving
  logic [ISB_DATA_W-1:0] rx_full;            // byte including current bit
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic push;

  // line synchronisers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_sync <= '1;
      sda_sync <= '1;
    end else begin
      scl_sync <= {scl_sync[ISB_SYNC_STAGES-2:0], scl_in};
      sda_sync <= {sda_sync[ISB_SYNC_STAGES-2:0], sda_in};
    end
  end

  // filtered levels: change only when stages two and three agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_q <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_q <= sda_sync[2];
      end
    end
  end

  // edges and bus conditions from the filtered levels
  assign scl_rise = (scl_sync[1] == scl_sync[2]) && scl_sync[2] && !scl_q;
  assign scl_fall = (scl_sync[1] == scl_sync[2]) && !scl_sync[2] && scl_q;
  assign start_det = scl_q && (sda_sync[1] == sda_sync[2]) && !sda_sync[2] && sda_q;
  assign stop_det = scl_q && (sda_sync[1] == sda_sync[2]) && sda_sync[2] && !sda_q;
  assign rx_full = {shreg[ISB_DATA_W-2:0], sda_q};
  assign push = (state == ISB_DATA_IN) && scl_fall && (bit_cnt == ISB_LAST_BIT)
    && fifo_in_ready;

  // bit counter: counts on falling scl, wraps after ack slot
  // preset to the ack slot so the fall that follows a start wraps to bit 0
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bit_cnt <= '0;
    end else if (start_det || stop_det) begin
      bit_cnt <= ISB_ACK_BIT;
    end else if (scl_fall) begin
      bit_cnt <= (bit_cnt == ISB_ACK_BIT) ? '0 : bit_cnt + 1'b1;
    end
  end

  // receive shifter, msb first on rising scl
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shreg <= '0;
    end else if (scl_rise && bit_cnt != ISB_ACK_BIT) begin
      shreg <= rx_full;
    end
  end

  // decoder state: byte decisions made at the falling edge ending bit 7; a read ends at the fall ending its ack slot
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ISB_IDLE;
    end else if (start_det) begin
      state <= ISB_CTRL;
    end else if (stop_det) begin
      state <= ISB_IDLE;
    end else if (scl_fall) begin
      unique case (state)
        ISB_IDLE, ISB_IGNORE: begin
          state <= state;
        end
        ISB_CTRL: begin
          if (bit_cnt == ISB_LAST_BIT) begin
            if (shreg[ISB_DATA_W-1 -: ISB_CODE_W] != control_code) begin
              state <= ISB_IGNORE;
            end else if (shreg[0]) begin
              state <= ISB_DATA_OUT;
            end else begin
              state <= ISB_WORD;
            end
          end
        end
        ISB_WORD: begin
          if (bit_cnt == ISB_LAST_BIT) begin
            state <= ISB_DATA_IN;
          end
        end
        ISB_DATA_IN: begin
          if (bit_cnt == ISB_LAST_BIT) begin
            // further bytes are ignored; the controller stops after one
            state <= ISB_IGNORE;
          end
        end
        ISB_DATA_OUT: begin
          // single-byte read; header ack slot passes, the nack slot ends it
          if (bit_cnt == ISB_ACK_BIT && !ack_drive) begin
            state <= ISB_IGNORE;
          end
        end
      endcase
    end
  end

  // block address and pointer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      block_address_bits <= '0;
      pointer <= '0;
    end else if (scl_fall && bit_cnt == ISB_LAST_BIT) begin
      if (state == ISB_CTRL && shreg[ISB_DATA_W-1 -: ISB_CODE_W] == control_code) begin
        block_address_bits <= shreg[ISB_DATA_W-ISB_CODE_W-1 -: ISB_BLK_W];
      end
      if (state == ISB_WORD) begin
        pointer <= {block_address_bits, shreg};
      end
    end
  end

  // ack driver: matched header, word address, or accepted data byte
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_drive <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_drive <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt == ISB_LAST_BIT) begin
        ack_drive <= (state == ISB_CTRL
          && shreg[ISB_DATA_W-1 -: ISB_CODE_W] == control_code)
          || state == ISB_WORD
          || (state == ISB_DATA_IN && fifo_in_ready);
      end else begin
        ack_drive <= 1'b0;
      end
    end
  end

  // read shifter: loaded at the fall that ends the header ack, shifted on the falls ending bits 0 to 6
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_byte <= '0;
      rd_active <= 1'b0;
    end else if (start_det || stop_det) begin
      rd_active <= 1'b0;
    end else if (scl_fall) begin
      if (state == ISB_DATA_OUT && bit_cnt == ISB_ACK_BIT && ack_drive) begin
        tx_byte <= rd_data;  // header ack over, first bit goes out
        rd_active <= 1'b1;
      end else if (state == ISB_DATA_OUT && bit_cnt == ISB_LAST_BIT) begin
        rd_active <= 1'b0;  // release for the controller's nack
      end else if (rd_active) begin
        tx_byte <= {tx_byte[ISB_DATA_W-2:0], 1'b1};  // msb first
      end
    end
  end

  assign rd_bit = tx_byte[ISB_DATA_W-1];

  // pin drive: open drain, only ever pulls low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= !(ack_drive || (rd_active && !rd_bit));
    end
  end

  // registered side outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_addr <= '0;
      busy <= 1'b0;
    end else begin
      rd_addr <= pointer;
      busy <= state != ISB_IDLE;
    end
  end

  // data byte enters the fifo at its ack, before any stop
  isb_fifo #(.WIDTH(FW), .DEPTH(ISB_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({pointer, shreg}),  // shreg holds the whole byte by this fall
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready || !wr_valid),
    .out_data(fifo_out_data)
  );

  // output stage register so outputs come from flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else if (wr_ready || !wr_valid) begin
      wr_valid <= fifo_out_valid;
      wr_addr <= fifo_out_data[FW-1 -: ISB_ADDR_W];
      wr_data <= fifo_out_data[ISB_DATA_W-1:0];
    end
  end

  // assertions
  // header byte complete, with its code compared against the programmed one
  sequence s_hdr_end;
    scl_fall && bit_cnt == ISB_LAST_BIT && state == ISB_CTRL;
  endsequence
  sequence s_code_bad;
    shreg[ISB_DATA_W-1 -: ISB_CODE_W] != control_code;
  endsequence
  a_ack_after_byte: assert property (@(posedge clock) disable iff (reset)
    $rose(ack_drive) |-> $past(bit_cnt) == ISB_LAST_BIT)
    else $error("ack raised outside ninth slot");
  a_no_drive_ignored: assert property (@(posedge clock) disable iff (reset)
    state == ISB_IGNORE && $past(state) == ISB_IGNORE && !$past(ack_drive)
    |=> sda_oe_n)
    else $error("sda driven in ignored transaction");
  a_push_at_ack: assert property (@(posedge clock) disable iff (reset)
    push |=> ack_drive && state == ISB_IGNORE)
    else $error("write committed without its acknowledge");
  a_restart_keeps_ptr: assert property (@(posedge clock) disable iff (reset)
    start_det |=> $stable(pointer))
    else $error("pointer changed on repeated start");
  a_abort_no_push: assert property (@(posedge clock) disable iff (reset)
    start_det |=> !push)
    else $error("write stored after repeated start");
  a_bad_code_silent: assert property (@(posedge clock) disable iff (reset)
    s_hdr_end ##0 s_code_bad |=> !ack_drive && state == ISB_IGNORE)
    else $error("mismatched control code answered");
  a_read_load: assert property (@(posedge clock) disable iff (reset)
    scl_fall && state == ISB_DATA_OUT && bit_cnt == ISB_ACK_BIT && ack_drive
    |=> rd_active && tx_byte == $past(rd_data))
    else $error("read byte not loaded after header ack");
endmodule
`default_nettype wire
